// >>> hw/level_monitor_consts.vh
/*
 * Register offsets, field positions and reset values of the supply level
 * status and interrupt block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef LEVEL_MONITOR_CONSTS_VH
`define LEVEL_MONITOR_CONSTS_VH

// Register offsets (byte registers)
`define OFS_ENABLE 3'h0
`define OFS_STATUS 3'h1
`define OFS_IRQ_EN 3'h2
`define OFS_FLAGS 3'h3
`define OFS_TEST_LO 3'h4
`define OFS_TEST_HI 3'h6
`define OFS_TEST_LO_B 3'h5
`define OFS_TEST_HI_B 3'h7

// Field positions
`define BIT_LOW 0
`define BIT_HIGH 1

// Reset values
`define RST_IRQ_EN 2'h0
`define RST_FLAGS 2'h0
`define RST_TEST 8'h00
`define RST_COND 1'b0
`define RST_SYNC 2'h0
`define RST_RDATA 8'h00

`endif

// >>> hw/supply_level_status_irq.v
/*
 * Status, change flags and interrupt merging of a supply sense monitor.
 * Assumes asynchronous comparator outputs (four low and two high trip levels per pin), level
 * sense enables and threshold selects from the enable register held
 * elsewhere, and a byte register port clocked by mclk.
 */
// Summary of operation
// - Status bit 1 shows high level, set at rising, cleared at falling point.
// - Status bit 0 shows low level, set below falling, cleared at rising.
// - Status register readable anytime, writes ignored.
// - High flag with high enable (bit 1) requests the interrupt.
// - Low flag with low enable (bit 0) requests the interrupt.
// - High change flag bit 1 sets on any change of high condition.
// - Low change flag bit 0 sets on any change of low condition.
// - Flags clear only by writing 1; writing 0 leaves them.
// - Only the high test register accepts writes, and only in special mode.
// - Interrupt request only while processor is in run mode.
// - Flags unchanged when entering or leaving stop mode.
// - Both condition bits forced to 0 when both level enables are clear.
// - Forced clearing of an active condition counts as a change.
// - Low and high sources, each gated, are ORed into one interrupt.
// - Two-bit low threshold select picks one of four low trip levels.
// - One-bit high threshold select picks one of two high trip levels.
// - Sense pin level enable has priority over supply pin enable.
`timescale 1ns/1ps
`default_nettype none
`include "level_monitor_consts.vh"

module supply_level_status_irq (
   input wire mclk,
   input wire reset_n,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire sense_pin_level_enable,
   input wire supply_pin_level_enable,
   input wire [1:0] low_threshold_select,
   input wire high_threshold_select,
   input wire run_mode,
   input wire special_mode,
   input wire [3:0] sense_low_cmp,
   input wire [1:0] sense_high_cmp,
   input wire [3:0] supply_low_cmp,
   input wire [1:0] supply_high_cmp,
   output reg high_level_condition,
   output reg low_level_condition,
   output reg module_irq
);

////////////////////////////////////////////////////////////////////////////
// Comparator selection
wire sense_on;
wire sensing;
reg low_sense_pick;
reg low_supply_pick;
reg high_sense_pick;
reg high_supply_pick;
reg low_raw;
reg high_raw;

assign sense_on = sense_pin_level_enable;
assign sensing = sense_pin_level_enable | supply_pin_level_enable;

// Low trip level on the sense pin
always @* begin
   low_sense_pick = 1'b0;
   case (low_threshold_select)
      2'h0: begin
         low_sense_pick = sense_low_cmp[0];
      end
      2'h1: begin
         low_sense_pick = sense_low_cmp[1];
      end
      2'h2: begin
         low_sense_pick = sense_low_cmp[2];
      end
      2'h3: begin
         low_sense_pick = sense_low_cmp[3];
      end
      default: begin
         low_sense_pick = 1'b0;
      end
   endcase
end

// Low trip level on the supply pin
always @* begin
   low_supply_pick = 1'b0;
   case (low_threshold_select)
      2'h0: begin
         low_supply_pick = supply_low_cmp[0];
      end
      2'h1: begin
         low_supply_pick = supply_low_cmp[1];
      end
      2'h2: begin
         low_supply_pick = supply_low_cmp[2];
      end
      2'h3: begin
         low_supply_pick = supply_low_cmp[3];
      end
      default: begin
         low_supply_pick = 1'b0;
      end
   endcase
end

// High trip level on the sense pin
always @* begin
   high_sense_pick = 1'b0;
   case (high_threshold_select)
      1'b0: begin
         high_sense_pick = sense_high_cmp[0];
      end
      1'b1: begin
         high_sense_pick = sense_high_cmp[1];
      end
      default: begin
         high_sense_pick = 1'b0;
      end
   endcase
end

// High trip level on the supply pin
always @* begin
   high_supply_pick = 1'b0;
   case (high_threshold_select)
      1'b0: begin
         high_supply_pick = supply_high_cmp[0];
      end
      1'b1: begin
         high_supply_pick = supply_high_cmp[1];
      end
      default: begin
         high_supply_pick = 1'b0;
      end
   endcase
end

// Sense pin wins when both enables are set
always @* begin
   low_raw = 1'b0;
   high_raw = 1'b0;
   if (sense_on) begin
      low_raw = low_sense_pick;
      high_raw = high_sense_pick;
   end else begin
      low_raw = low_supply_pick;
      high_raw = high_supply_pick;
   end
end

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser; only the second stage is read
reg [1:0] low_sync_r;
reg [1:0] high_sync_r;
wire low_seen;
wire high_seen;

assign low_seen = low_sync_r[1];
assign high_seen = high_sync_r[1];

always @(posedge mclk) begin
   if (!reset_n) begin
      low_sync_r <= `RST_SYNC;
   end else begin
      low_sync_r <= {low_sync_r[0], low_raw};
   end
end

always @(posedge mclk) begin
   if (!reset_n) begin
      high_sync_r <= `RST_SYNC;
   end else begin
      high_sync_r <= {high_sync_r[0], high_raw};
   end
end

////////////////////////////////////////////////////////////////////////////
// Condition bits
wire low_nxt;
wire high_nxt;
reg low_cond_r;
reg high_cond_r;

assign low_nxt = sensing & low_seen;
assign high_nxt = sensing & high_seen;

always @(posedge mclk) begin
   if (!reset_n) begin
      low_cond_r <= `RST_COND;
   end else begin
      low_cond_r <= low_nxt;
   end
end

always @(posedge mclk) begin
   if (!reset_n) begin
      high_cond_r <= `RST_COND;
   end else begin
      high_cond_r <= high_nxt;
   end
end

always @(posedge mclk) begin
   if (!reset_n) begin
      high_level_condition <= `RST_COND;
   end else begin
      high_level_condition <= high_nxt;
   end
end

always @(posedge mclk) begin
   if (!reset_n) begin
      low_level_condition <= `RST_COND;
   end else begin
      low_level_condition <= low_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////
// Change flags; a forced clearing is also a change
reg [1:0] flags_r;
wire wr_flags;
wire low_clear;
wire high_clear;
wire low_change;
wire high_change;
reg low_flag_nxt;
reg high_flag_nxt;
wire [1:0] flags_nxt;

assign wr_flags = reg_wr && (reg_addr == `OFS_FLAGS);
assign low_clear = wr_flags & reg_wdata[`BIT_LOW];
assign high_clear = wr_flags & reg_wdata[`BIT_HIGH];
assign low_change = low_nxt ^ low_cond_r;
assign high_change = high_nxt ^ high_cond_r;
assign flags_nxt = {high_flag_nxt, low_flag_nxt};

// Set wins over a clear in the same cycle
always @* begin
   low_flag_nxt = flags_r[`BIT_LOW];
   if (low_change) begin
      low_flag_nxt = 1'b1;
   end else if (low_clear) begin
      low_flag_nxt = 1'b0;
   end
end

always @* begin
   high_flag_nxt = flags_r[`BIT_HIGH];
   if (high_change) begin
      high_flag_nxt = 1'b1;
   end else if (high_clear) begin
      high_flag_nxt = 1'b0;
   end
end

// Stop mode has no path into the flags
always @(posedge mclk) begin
   if (!reset_n) begin
      flags_r <= `RST_FLAGS;
   end else begin
      flags_r <= flags_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////
// Interrupt enables and request
reg [1:0] irq_en_r;
reg [1:0] irq_en_nxt;
wire wr_irq_en;
wire low_src;
wire high_src;
wire irq_nxt;

assign wr_irq_en = reg_wr && (reg_addr == `OFS_IRQ_EN);
assign low_src = flags_nxt[`BIT_LOW] & irq_en_r[`BIT_LOW];
assign high_src = flags_nxt[`BIT_HIGH] & irq_en_r[`BIT_HIGH];
assign irq_nxt = run_mode & (low_src | high_src);

always @* begin
   irq_en_nxt = irq_en_r;
   if (wr_irq_en) begin
      irq_en_nxt = reg_wdata[1:0];
   end
end

always @(posedge mclk) begin
   if (!reset_n) begin
      irq_en_r <= `RST_IRQ_EN;
   end else begin
      irq_en_r <= irq_en_nxt;
   end
end

always @(posedge mclk) begin
   if (!reset_n) begin
      module_irq <= 1'b0;
   end else begin
      module_irq <= irq_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////
// Factory test register
reg [7:0] test_hi_r;
reg [7:0] test_hi_nxt;
wire wr_test;

assign wr_test = reg_wr && special_mode &&
   (reg_addr == `OFS_TEST_HI || reg_addr == `OFS_TEST_HI_B);

always @* begin
   test_hi_nxt = test_hi_r;
   if (wr_test) begin
      test_hi_nxt = reg_wdata;
   end
end

always @(posedge mclk) begin
   if (!reset_n) begin
      test_hi_r <= `RST_TEST;
   end else begin
      test_hi_r <= test_hi_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////
// Read port; status register has no write path
reg [7:0] rdata_nxt;

always @* begin
   rdata_nxt = `RST_RDATA;
   if (reg_rd) begin
      case (reg_addr)
         `OFS_ENABLE: begin
            rdata_nxt = `RST_RDATA;
         end
         `OFS_STATUS: begin
            rdata_nxt = {6'h00, high_cond_r, low_cond_r};
         end
         `OFS_IRQ_EN: begin
            rdata_nxt = {6'h00, irq_en_r};
         end
         `OFS_FLAGS: begin
            rdata_nxt = {6'h00, flags_r};
         end
         `OFS_TEST_LO, `OFS_TEST_LO_B: begin
            rdata_nxt = `RST_RDATA;
         end
         `OFS_TEST_HI, `OFS_TEST_HI_B: begin
            rdata_nxt = test_hi_r;
         end
         default: begin
            rdata_nxt = `RST_RDATA;
         end
      endcase
   end
end

always @(posedge mclk) begin
   if (!reset_n) begin
      reg_rdata <= `RST_RDATA;
   end else begin
      reg_rdata <= rdata_nxt;
   end
end

endmodule // supply_level_status_irq
`default_nettype wire

// >>> verification/level_status_sva.sv
/* Port checker for supply_level_status_irq.
   Assumes a bind onto the design top, names matching its ports. */
`timescale 1ns/1ps
`default_nettype none
module level_status_sva (
   input wire mclk,
   input wire reset_n,
   input wire [2:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire sense_pin_level_enable,
   input wire supply_pin_level_enable,
   input wire [1:0] low_threshold_select,
   input wire high_threshold_select,
   input wire run_mode,
   input wire [3:0] sense_low_cmp,
   input wire [1:0] sense_high_cmp,
   input wire high_level_condition,
   input wire low_level_condition,
   input wire module_irq
);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
////////////////////////////////////////////////////////////////////////////
a_rd_idle:
   assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata");
a_rsv_zero:
   assert property (reg_rd && reg_addr == 3'h4 |=> reg_rdata == 8'h00)
   else $error("rsvd");
a_stat_read:
   assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata == {6'h00,
      $past(high_level_condition), $past(low_level_condition)})
   else $error("status");
a_high_set:
   assert property ((sense_pin_level_enable &&
      sense_high_cmp[high_threshold_select])[*4] |-> high_level_condition)
   else $error("high");
a_sense_first:
   assert property ((sense_pin_level_enable &&
      !sense_high_cmp[high_threshold_select])[*4] |-> !high_level_condition)
   else $error("prio");
a_low_set:
   assert property ((sense_pin_level_enable &&
      sense_low_cmp[low_threshold_select])[*4] |-> low_level_condition)
   else $error("low");
a_off_zero:
   assert property ((!sense_pin_level_enable && !supply_pin_level_enable)[*4]
      |-> !high_level_condition && !low_level_condition) else $error("off");
a_irq_run:
   assert property (!run_mode[*2] |-> !module_irq) else $error("irq");
cover property ($rose(module_irq));
cover property ($fell(high_level_condition));
cover property ($rose(low_level_condition));
endmodule // level_status_sva
bind supply_level_status_irq level_status_sva level_status_sva_inst (.*);
`default_nettype wire

// >>> verification/supply_level_status_irq_test.sv
/* Directed testbench for supply_level_status_irq.
   Assumes the design and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CK(n,e,s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module supply_level_status_irq_test;
logic mclk, reset_n, wr, rd, s_en, u_en, hs, run, sp;
logic [2:0] a;
logic [7:0] wd, d;
logic [1:0] ls, shc, uhc;
logic [3:0] slc, ulc;
wire [7:0] rdata;
wire hc, lc, irq;
int mismatches, n_compared;
supply_level_status_irq supply_level_status_irq_inst (.mclk(mclk),
   .reset_n(reset_n), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
   .reg_rd(rd), .reg_rdata(rdata), .sense_pin_level_enable(s_en),
   .supply_pin_level_enable(u_en), .low_threshold_select(ls),
   .high_threshold_select(hs), .run_mode(run), .special_mode(sp),
   .sense_low_cmp(slc), .sense_high_cmp(shc), .supply_low_cmp(ulc),
   .supply_high_cmp(uhc), .high_level_condition(hc),
   .low_level_condition(lc), .module_irq(irq));
task acc(input [2:0] ad, input w, input [7:0] v);
   @(posedge mclk) begin a <= ad; wd <= v; wr <= w; rd <= !w; end
   @(posedge mclk) begin wr <= 0; rd <= 0; end
   #1 d = rdata;
endtask
task t_high;
   @(posedge mclk) begin s_en <= 1; u_en <= 1; hs <= 1; shc <= 2'h2;
      uhc <= 2'h3; ulc <= 4'hF; end
   acc(3'h2, 1, 8'h02);
   repeat (4) @(posedge mclk);
   #1 `CK("hc", 1'b1, hc)
   `CK("irq", 1'b1, irq)
   acc(3'h3, 0, 0); `CK("flg", 8'h02, d)
   acc(3'h3, 1, 8'h01); acc(3'h3, 0, 0); `CK("w0", 8'h02, d)
   acc(3'h3, 1, 8'h02); acc(3'h3, 0, 0); `CK("w1", 8'h00, d)
   `CK("irq0", 1'b0, irq)
   acc(3'h1, 1, 8'hFF); acc(3'h1, 0, 0); `CK("st", 8'h02, d)
   $display("high test done");
endtask
task t_low;
   acc(3'h2, 1, 8'h01);
   @(posedge mclk) hs <= 0;
   repeat (4) @(posedge mclk);
   #1 `CK("hc0", 1'b0, hc)
   `CK("irqm", 1'b0, irq)
   for (int i = 0; i < 4; i++) begin
      @(posedge mclk) begin ls <= i[1:0]; slc <= 4'h1 << i[1:0]; end
      repeat (4) @(posedge mclk);
      #1 `CK("lc", 1'b1, lc)
      @(posedge mclk) slc <= ~(4'h1 << i[1:0]);
      repeat (4) @(posedge mclk);
      #1 `CK("lc0", 1'b0, lc)
   end
   `CK("irql", 1'b1, irq)
   acc(3'h3, 0, 0); `CK("fl", 8'h03, d)
   @(posedge mclk) slc <= 4'hF;
   repeat (4) @(posedge mclk);
   acc(3'h3, 1, 8'h03);
   @(posedge mclk) begin run <= 0; s_en <= 0; u_en <= 0; end
   repeat (4) @(posedge mclk);
   #1 `CK("off", 1'b0, lc)
   `CK("stop", 1'b0, irq)
   acc(3'h3, 0, 0); `CK("fx", 8'h01, d)
   @(posedge mclk) run <= 1;
   repeat (2) @(posedge mclk);
   #1 `CK("irqx", 1'b1, irq)
   $display("low test done");
endtask
task t_test;
   acc(3'h6, 1, 8'hA5); acc(3'h6, 0, 0); `CK("t0", 8'h00, d)
   @(posedge mclk) sp <= 1;
   acc(3'h6, 1, 8'hA5); acc(3'h7, 0, 0); `CK("t1", 8'hA5, d)
   acc(3'h0, 0, 0); `CK("un", 8'h00, d)
   $display("test register done");
endtask
task t_quiet;
   @(posedge mclk) begin s_en <= 1; slc <= 4'hF; end
   repeat (4) @(posedge mclk);
   acc(3'h2, 1, 8'h00);
   acc(3'h3, 1, 8'h03); acc(3'h3, 0, 0); `CK("q0", 8'h00, d)
   @(posedge mclk) begin a <= 3'h3; wd <= 8'h03; wr <= 1; s_en <= 0; end
   @(posedge mclk) wr <= 0;
   repeat (4) @(posedge mclk);
   #1 `CK("qirq", 1'b0, irq)
   acc(3'h3, 0, 0); `CK("qset", 8'h01, d)
   $display("quiet test done");
endtask
task complete_run;
   $display("compared %0d mismatches %0d", n_compared, mismatches);
   if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
   else
      $display("Simulation failed");
   $finish;
endtask
initial begin
   mclk = 0;
   forever #12.5 mclk = ~mclk;
end
initial begin
   {reset_n, wr, rd, s_en, u_en, hs, run, sp, a, wd, ls, shc, uhc} = 0;
   {slc, ulc} = 0;
   repeat (3) @(posedge mclk);
   reset_n <= 1;
   run <= 1;
   t_high;
   t_low;
   t_test;
   t_quiet;
   complete_run;
end
initial begin
   #20000;
   mismatches++;
   complete_run;
end
endmodule // supply_level_status_irq_test
`default_nettype wire
